//--- sbp_consts.vh
`ifndef SBP_CONSTS_VH
`define SBP_CONSTS_VH

// ----------------------------------------------------------------------------
// Group map with the top/bottom selector at zero
// ----------------------------------------------------------------------------
`define SBP_GROUPS          286
`define SBP_LAST_GROUP      9'h11D
`define SBP_TOP_BLOCK_FIRST 8'hFE
`define SBP_TOP_GROUP_BASE  9'h0FE

// ----------------------------------------------------------------------------
// Register byte offsets on the Wishbone slave
// ----------------------------------------------------------------------------
`define SBP_REG_CTRL        4'h0
`define SBP_REG_ADDR        4'h1
`define SBP_REG_STATUS      4'h2
`define SBP_REG_QUERY       4'h3

// ----------------------------------------------------------------------------
// Command codes written to the control register bits 2:0
// ----------------------------------------------------------------------------
`define SBP_CMD_PROG_PPB    3'h1
`define SBP_CMD_ERASE_PPB   3'h2
`define SBP_CMD_READ_PPB    3'h3
`define SBP_CMD_DYB_WRITE   3'h4
`define SBP_CMD_GUARD_CLR   3'h5
`define SBP_CMD_UNLOCK_OK   3'h6
`define SBP_CMD_SOFT_RST    3'h7

// ----------------------------------------------------------------------------
// Timing in microseconds and cycle counts at 200 MHz
// ----------------------------------------------------------------------------
`define SBP_CLK_MHZ         200
`define SBP_PROG_US         200
`define SBP_ERASE_US        45000
`define SBP_PROG_CYCLES     (`SBP_PROG_US * `SBP_CLK_MHZ)
`define SBP_ERASE_CYCLES    (`SBP_ERASE_US * `SBP_CLK_MHZ)
`define SBP_READ_LATENCY    3'h4

`endif

//--- sbp_bit_mem.v
`include "sbp_consts.vh"

module sbp_bit_mem #(
    parameter DEPTH   = `SBP_GROUPS,
    parameter AW      = 9,
    parameter INIT    = 1'b1
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          reset_n,
    // Control
    input  wire          clearAll,
    input  wire          setAll,
    input  wire          writeEn,
    input  wire [AW-1:0] writeAddr,
    input  wire          writeData,
    input  wire [AW-1:0] readAddr,
    // Registered read data
    output reg           readData
);

    reg  [DEPTH-1:0] bits = {DEPTH{INIT}};
    integer          i;

    // The store starts erased; a copy with reset tied high keeps its contents
    // through hardware reset, as non-volatile bits must.
    always @(posedge core_clk) begin
        if (!reset_n) begin
            bits     <= {DEPTH{INIT}};
            readData <= INIT;
        end else begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                if (setAll)
                    bits[i] <= 1'b1;
                else if (clearAll)
                    bits[i] <= 1'b0;
                else if (writeEn && writeAddr == i[AW-1:0])
                    bits[i] <= writeData;
            end
            readData <= (readAddr < DEPTH) ? bits[readAddr] : INIT;
        end
    end

endmodule

//--- sbp_group_map.v
`include "sbp_consts.vh"

module sbp_group_map (
    // Byte address in, group number out
    input  wire [23:0] byteAddr,
    output wire [8:0]  group
);

    wire [7:0] blockNum;

    assign blockNum = byteAddr[23:16];
    // Upper two blocks split into 4 KB sectors, the rest are whole blocks.
    assign group = (blockNum >= `SBP_TOP_BLOCK_FIRST) ?
                   (`SBP_TOP_GROUP_BASE + {4'h0, blockNum[0], byteAddr[15:12]}) :
                   {1'b0, blockNum};

endmodule

//--- sbp_protect.v
// How it works
// - Selector zero: blocks 0-253 one group each, top 32 sectors groups 254-285.
// - One persistent bit per group, programmed singly to 0, erased together to 1.
// - Erase handles preprogram and verify internally with no host involvement.
// - Program busy for page program time, erase busy for sector erase time.
// - Busy progress visible in status register for host polling.
// - Persistent bit read completes after the normal array read latency.
// - During persistent bit programming no array data is delivered.
// - No single-bit erase; group erase ignores the address.
// - Persistent bits read erased, unprotected, as delivered.
// - Dynamic bit per group, written freely: 0 protects, 1 unprotects.
// - Dynamic bit matters only where the persistent bit is erased.
// - Guard bit 0 makes persistent program or erase fail without change.
// - Persistent mode: guard set at hardware reset, never set again by command.
// - Password mode: guard cleared at hardware reset, set only by good unlock.
// - Group protected when its persistent or dynamic bit is 0.
// - Guard clear command clears the guard bit.
// - Software reset leaves the guard bit unchanged.
// - Any reset returns all dynamic bits to unprotected.
`include "sbp_consts.vh"

module sbp_protect #(
    parameter PROG_CYCLES  = `SBP_PROG_CYCLES,
    parameter ERASE_CYCLES = `SBP_ERASE_CYCLES
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset_n,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Mode strap, low selects password mode
    input  wire        persistentModeSel,
    // Array access check
    input  wire [23:0] arrayAddr,
    output reg         arrayProtected,
    output reg         arrayReadBlocked
);

    // ------------------------------------------------------------------------
    // Mode strap synchroniser
    // ------------------------------------------------------------------------
    reg modeMeta;
    reg modeSync;
    // The mode is taken once per hardware reset, so a strap that moves during
    // normal operation can never turn an unlock command into a guard bypass.
    reg modeLatched;
    always @(posedge core_clk) begin
        modeMeta <= persistentModeSel;
        modeSync <= modeMeta;
    end

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire        busReq;
    wire        wrCtrl;
    wire        wrAddr;
    wire [2:0]  cmd;
    reg  [23:0] cmdAddr;
    reg         busy;
    // The count covers the longest erase at the default clock with room to spare;
    // a clock or an erase time up to 477 times larger still fits.
    reg  [31:0] busyCnt;
    reg         progBusy;
    reg         eraseBusy;
    reg         failFlag;
    reg         guardBit;
    reg         guardInitDone;
    reg         readPending;
    reg  [2:0]  readCnt;
    reg         readValid;
    reg         readBit;
    reg         readDyb;

    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrCtrl = busReq && wb_we_i && wb_adr_i == `SBP_REG_CTRL && wb_sel_i[0];
    assign wrAddr = busReq && wb_we_i && wb_adr_i == `SBP_REG_ADDR;
    assign cmd    = wb_dat_i[2:0];

    // ------------------------------------------------------------------------
    // Group lookup for command address and array address
    // ------------------------------------------------------------------------
    wire [8:0] cmdGroup;
    wire [8:0] arrayGroup;
    wire       ppbRd;
    wire       dybRd;
    wire       ppbArr;
    wire       dybArr;

    sbp_group_map cmdMap (
        .byteAddr (cmdAddr),
        .group    (cmdGroup)
    );
    sbp_group_map arrMap (
        .byteAddr (arrayAddr),
        .group    (arrayGroup)
    );

    // ------------------------------------------------------------------------
    // Command decode, ignored while a persistent bit operation is busy
    // ------------------------------------------------------------------------
    wire issue;
    wire isProg;
    wire isErase;
    wire isRead;
    wire isDybWrite;
    wire isGuardClr;
    wire isUnlock;
    wire ppbWriteOk;
    wire softRst;

    assign issue      = wrCtrl && !busy;
    assign isProg     = issue && cmd == `SBP_CMD_PROG_PPB;
    assign isErase    = issue && cmd == `SBP_CMD_ERASE_PPB;
    assign isRead     = issue && cmd == `SBP_CMD_READ_PPB;
    assign isDybWrite = issue && cmd == `SBP_CMD_DYB_WRITE;
    assign isGuardClr = issue && cmd == `SBP_CMD_GUARD_CLR;
    assign isUnlock   = issue && cmd == `SBP_CMD_UNLOCK_OK;
    assign ppbWriteOk = (isProg || isErase) && guardBit;
    assign softRst    = issue && cmd == `SBP_CMD_SOFT_RST;

    // Persistent bits change when the busy period ends, so a failed or aborted
    // operation never leaves a partial result.
    wire progDone;
    wire eraseDone;
    assign progDone  = progBusy && busyCnt == 32'h00000001;
    assign eraseDone = eraseBusy && busyCnt == 32'h00000001;

    // ------------------------------------------------------------------------
    // Protection bit stores
    // ------------------------------------------------------------------------
    // Each store is kept twice so the command side and the array check each
    // own a read port; area is traded for having no read arbitration.
    sbp_bit_mem #(.INIT(1'b1)) ppbMem (
        .core_clk  (core_clk),
        .reset_n   (1'b1),
        .clearAll  (1'b0),
        .setAll    (eraseDone),
        .writeEn   (progDone),
        .writeAddr (cmdGroup),
        .writeData (1'b0),
        .readAddr  (cmdGroup),
        .readData  (ppbRd)
    );
    sbp_bit_mem #(.INIT(1'b1)) dybMem (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .clearAll  (1'b0),
        .setAll    (softRst),
        .writeEn   (isDybWrite),
        .writeAddr (cmdGroup),
        .writeData (wb_dat_i[8]),
        .readAddr  (cmdGroup),
        .readData  (dybRd)
    );
    sbp_bit_mem #(.INIT(1'b1)) ppbArrMem (
        .core_clk  (core_clk),
        .reset_n   (1'b1),
        .clearAll  (1'b0),
        .setAll    (eraseDone),
        .writeEn   (progDone),
        .writeAddr (cmdGroup),
        .writeData (1'b0),
        .readAddr  (arrayGroup),
        .readData  (ppbArr)
    );
    sbp_bit_mem #(.INIT(1'b1)) dybArrMem (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .clearAll  (1'b0),
        .setAll    (softRst),
        .writeEn   (isDybWrite),
        .writeAddr (cmdGroup),
        .writeData (wb_dat_i[8]),
        .readAddr  (arrayGroup),
        .readData  (dybArr)
    );

    // ------------------------------------------------------------------------
    // Guard bit and busy sequencer
    // ------------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!reset_n) begin
            guardBit      <= 1'b0;
            guardInitDone <= 1'b0;
            modeLatched   <= 1'b1;
            busy          <= 1'b0;
            progBusy      <= 1'b0;
            eraseBusy     <= 1'b0;
            busyCnt       <= 32'h00000000;
            failFlag      <= 1'b0;
            cmdAddr       <= 24'h000000;
        end else begin
            if (!guardInitDone) begin
                // Caught after release so the strap is never a reset value.
                guardInitDone <= 1'b1;
                modeLatched   <= modeSync;
                guardBit      <= modeSync;
            end else if (isGuardClr) begin
                guardBit <= 1'b0;
            end else if (isUnlock && !modeLatched) begin
                guardBit <= 1'b1;
            end
            // Software reset deliberately does not touch the guard bit.
            // The address is frozen while busy, because the group written at
            // the end of a program is the one that cmdAddr names then.
            if (wrAddr && !busy)
                cmdAddr <= wb_dat_i[23:0];
            // The fail flag holds the outcome of the last program or erase
            // request until the next one, so a late poll still sees it.
            if (isProg || isErase)
                failFlag <= !guardBit;
            if (ppbWriteOk) begin
                busy      <= 1'b1;
                progBusy  <= isProg;
                eraseBusy <= isErase;
                busyCnt   <= isProg ? PROG_CYCLES : ERASE_CYCLES;
            end else if (busy) begin
                if (busyCnt == 32'h00000001) begin
                    busy      <= 1'b0;
                    progBusy  <= 1'b0;
                    eraseBusy <= 1'b0;
                end
                busyCnt <= busyCnt - 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Persistent bit read with array access latency
    // ------------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!reset_n) begin
            readPending <= 1'b0;
            readCnt     <= 3'h0;
            readValid   <= 1'b0;
            readBit     <= 1'b1;
            readDyb     <= 1'b1;
        end else if (isRead) begin
            readPending <= 1'b1;
            readValid   <= 1'b0;
            readCnt     <= `SBP_READ_LATENCY;
        end else if (readPending) begin
            readCnt <= readCnt - 3'h1;
            if (readCnt == 3'h1) begin
                readPending <= 1'b0;
                readValid   <= 1'b1;
                readBit     <= ppbRd;
                readDyb     <= dybRd;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Array protection outputs
    // ------------------------------------------------------------------------
    // The check lags arrayAddr by two cycles; the array controller must allow
    // for that before it starts a program or erase on a new address.
    always @(posedge core_clk) begin
        if (!reset_n) begin
            arrayProtected   <= 1'b1;
            arrayReadBlocked <= 1'b0;
        end else begin
            arrayProtected   <= !ppbArr || !dybArr;
            arrayReadBlocked <= progBusy;
        end
    end

    // ------------------------------------------------------------------------
    // Wishbone answer, one wait state
    // ------------------------------------------------------------------------
    // Ack is registered from the request and blocks it for one cycle, so a
    // request held through its ack edge is never taken twice.
    always @(posedge core_clk) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            if (busReq && !wb_we_i) begin
                case (wb_adr_i)
                    `SBP_REG_ADDR:   wb_dat_o <= {8'h00, cmdAddr};
                    `SBP_REG_STATUS: wb_dat_o <= {26'h0, readValid, failFlag,
                                                  guardBit, eraseBusy, progBusy, busy};
                    `SBP_REG_QUERY:  wb_dat_o <= {22'h0, readPending, 1'b0,
                                                  6'h0, readDyb, readBit};
                    default:         wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

//--- sbp_host.sv
module sbp_host (
    // Clock and bus answer
    input  wire        core_clk,
    input  wire        ack,
    input  wire [31:0] rdData,
    // Bus request
    output reg         cyc,
    output reg         stb,
    output reg         we,
    output reg  [3:0]  adr,
    output reg  [3:0]  sel,
    output reg  [31:0] wrData
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'h0;
        wrData = 32'h0;
    end

    // Released data lines flip so a stale word is never mistaken for a fresh one.
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wrData <= d;
        @(posedge core_clk);
        while (ack !== 1'b1) @(posedge core_clk);
        q = rdData;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        wrData <= ~d;
    endtask
endmodule

//--- sbp_protect_monitor.sv
module sbp_protect_monitor #(
    parameter PROG_CYCLES  = 20,
    parameter ERASE_CYCLES = 50
) (
    // Clock and reset
    input wire        core_clk,
    input wire        reset_n,
    // Wishbone
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // Array side
    input wire        persistentModeSel,
    input wire [23:0] arrayAddr,
    input wire        arrayProtected,
    input wire        arrayReadBlocked
);
    wire       req = wb_cyc_i && wb_stb_i;
    wire       ctrlProg = req && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0] && wb_dat_i[2:0] == 3'h1;
    reg [31:0] busyLen;

    always @(posedge core_clk) begin
        busyLen <= (!reset_n || !arrayReadBlocked) ? 32'h0 : busyLen + 32'h1;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_ACK_NEXT: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("ack without request");
    AST_RESET_VAL: assert property (disable iff (1'b0) !reset_n |=> !wb_ack_o && wb_dat_o == 32'h0 && arrayProtected && !arrayReadBlocked) else $error("bad reset outputs");
    AST_BLK_HOLD: assert property ($rose(arrayReadBlocked) |-> arrayReadBlocked[*8]) else $error("program busy too short");
    AST_BLK_CAUSE: assert property ($rose(arrayReadBlocked) |-> $past(ctrlProg) || $past(ctrlProg, 2)) else $error("blocked without program");
    AST_BLK_MAX: assert property (busyLen <= PROG_CYCLES + 4) else $error("program busy too long");
    AST_BLK_MIN: assert property ($fell(arrayReadBlocked) |-> $past(busyLen) >= PROG_CYCLES - 4) else $error("program ended early");
    AST_DAT_HOLD: assert property ($past(!(req && !wb_we_i)) |-> $stable(wb_dat_o)) else $error("read data moved");
endmodule

bind sbp_protect sbp_protect_monitor #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) chk (
    .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .persistentModeSel(persistentModeSel), .arrayAddr(arrayAddr), .arrayProtected(arrayProtected),
    .arrayReadBlocked(arrayReadBlocked));

//--- sector_block_protect_bits_bench.sv
`include "sbp_consts.vh"

module sector_block_protect_bits_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        modeSel = 1'b1;
    logic [23:0] arrayAddr = 24'h0;
    wire         cyc, stb, we, ack, prot, blk;
    wire  [3:0]  adr, sel;
    wire  [31:0] wdat, rdat;
    logic [31:0] q;
    int          mismatches = 0;
    int          nCompared = 0;

    always #2.5 core_clk = ~core_clk;

    sbp_protect #(.PROG_CYCLES(20), .ERASE_CYCLES(50)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .persistentModeSel(modeSel), .arrayAddr(arrayAddr), .arrayProtected(prot), .arrayReadBlocked(blk));
    sbp_host host (.core_clk(core_clk), .ack(ack), .rdData(rdat), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .wrData(wdat));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Only byte zero of a sector or block is handed over as a group address.
    task automatic cmd(input logic [23:0] a, input logic [2:0] c, input logic v);
        host.xfer(1'b1, `SBP_REG_ADDR, {8'h00, a}, q);
        host.xfer(1'b1, `SBP_REG_CTRL, {23'h0, v, 5'h0, c}, q);
    endtask

    task automatic rd(input logic [3:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic waitIdle();
        rd(`SBP_REG_STATUS);
        while (q[0] !== 1'b0) rd(`SBP_REG_STATUS);
    endtask

    task automatic expProt(input logic [23:0] a, input logic e);
        arrayAddr <= a;
        repeat (3) @(posedge core_clk);
        chk("arrayProtected", {31'h0, e}, {31'h0, prot});
    endtask

    task automatic readBits(input logic [23:0] a, input logic [1:0] e);
        cmd(a, `SBP_CMD_READ_PPB, 1'b0);
        rd(`SBP_REG_STATUS);
        chk("readValid early", 32'h0, {31'h0, q[5]});
        repeat (2) @(posedge core_clk);
        rd(`SBP_REG_QUERY);
        chk("query bits", {30'h0, e}, {30'h0, q[1:0]});
        chk("read pending", 32'h0, {31'h0, q[9]});
        rd(`SBP_REG_STATUS);
        chk("readValid late", 32'h1, {31'h0, q[5]});
        rd(`SBP_REG_ADDR);
        chk("address register", {8'h00, a}, q);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic sPower();
        rd(`SBP_REG_STATUS);
        chk("guard persistent", 32'h1, {31'h0, q[3]});
        expProt(24'hFFF000, 1'b0);
        readBits(24'hFF0000, 2'b11);
    endtask

    task automatic sDyb();
        cmd(24'h020000, `SBP_CMD_DYB_WRITE, 1'b0);
        expProt(24'h02FFFF, 1'b1);
        expProt(24'h030000, 1'b0);
        cmd(24'h020000, `SBP_CMD_DYB_WRITE, 1'b1);
        expProt(24'h020000, 1'b0);
    endtask

    task automatic sProg();
        logic [23:0] pa [2] = '{24'h010000, 24'hFE1000};
        logic [23:0] ca [6] = '{24'h01FFFF, 24'h020000, 24'h00FFFF, 24'hFE1FFF, 24'hFE0FFF, 24'hFE2000};
        logic        ce [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        foreach (pa[i]) begin
            cmd(pa[i], `SBP_CMD_PROG_PPB, 1'b0);
            rd(`SBP_REG_STATUS);
            chk("prog busy", 32'h3, {30'h0, q[1:0]});
            chk("array read blocked", 32'h1, {31'h0, blk});
            waitIdle();
            chk("array read free", 32'h0, {31'h0, blk});
        end
        foreach (ca[i]) expProt(ca[i], ce[i]);
        readBits(24'hFE1000, 2'b10);
        cmd(24'h010000, `SBP_CMD_DYB_WRITE, 1'b1);
        expProt(24'h010000, 1'b1);
    endtask

    task automatic sErase();
        cmd(24'h000000, `SBP_CMD_ERASE_PPB, 1'b0);
        rd(`SBP_REG_STATUS);
        chk("erase busy", 32'h1, {31'h0, q[2]});
        waitIdle();
        expProt(24'h010000, 1'b0);
        expProt(24'hFE1000, 1'b0);
    endtask

    // The guard is dropped while every persistent bit is still erased from sErase.
    task automatic sGuard();
        cmd(24'h000000, `SBP_CMD_GUARD_CLR, 1'b0);
        rd(`SBP_REG_STATUS);
        chk("guard cleared", 32'h0, {31'h0, q[3]});
        cmd(24'h030000, `SBP_CMD_PROG_PPB, 1'b0);
        rd(`SBP_REG_STATUS);
        chk("prog refused", 32'h1, {31'h0, q[4]});
        waitIdle();
        expProt(24'h030000, 1'b0);
        cmd(24'h030000, `SBP_CMD_DYB_WRITE, 1'b0);
        cmd(24'h000000, `SBP_CMD_SOFT_RST, 1'b0);
        expProt(24'h030000, 1'b0);
        cmd(24'h000000, `SBP_CMD_UNLOCK_OK, 1'b0);
        rd(`SBP_REG_STATUS);
        chk("guard kept", 32'h0, {31'h0, q[3]});
    endtask

    task automatic sPassword();
        modeSel <= 1'b0;
        reset_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(`SBP_REG_STATUS);
        chk("guard password", 32'h0, {31'h0, q[3]});
        cmd(24'h000000, `SBP_CMD_UNLOCK_OK, 1'b0);
        waitIdle();
        chk("guard unlocked", 32'h1, {31'h0, q[3]});
        cmd(24'h030000, `SBP_CMD_PROG_PPB, 1'b0);
        waitIdle();
        expProt(24'h030000, 1'b1);
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        sPower();
        sDyb();
        sProg();
        sErase();
        sGuard();
        sPassword();
        complete_run();
    end

    initial begin
        #200000;
        mismatches++;
        complete_run();
    end
endmodule
